//--- dac_update_control.sv
// Top of the DAC update control block: format, buffering, strobe modes, events
//
// Function
// - Supply-reference switch bit 0 closes the analog-supply reference switch.
// - Unsigned format: code 0x0 lowest output, 0xFFF highest.
// - Two's complement: 0x800 lowest, 0x000 midscale, 0x7FF highest.
// - Format field bits 25:24: 00 unsigned, 01 two's complement, others reserved.
// - Direct mode: current-value write changes the converter code at once.
// - Buffered mode: next value copied to current on update-clock rising edge.
// - Every buffered copy pulses a DMA trigger to refill the buffer.
// - Every buffered copy sets the buffer-reload interrupt condition.
// - Update clock comes from peripheral clock via programmable divider.
// - Strobe-enable bit 28 makes buffered transfers depend on the strobe.
// - Strobe enabled with level bit 29 clear and divider not 1 selects edge-sync mode.
// - Edge-sync: copy on first update-clock edge after a strobe rising edge.
// - Edge-immediate: divider set to 1, copy starts from strobe rising edge.
// - Level mode: copy on every update-clock edge while strobe is high.
// - Buffer-empty event drives both the interrupt and a DMA refill request.
// - Interrupt status bit 0 reports pending buffer-empty.
// - Interrupt reaches processor only when mask bit 0 is set.
// - Pending status also readable in the shared analog interrupt-cause bit.
// - Code bits 7:0 drive ladder; bits 11:8 decode to 15-line thermometer.
`timescale 1ns/1ps
module dac_update_control
    import dac_pkg::*;
#(
    parameter int CODE_W = DAC_CODE_W,
    parameter int DIV_W  = DAC_DIV_W
) (
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    // Configuration
    input  wire logic [1:0]             code_format_select_in,
    input  wire logic                   buffered_mode_in,
    input  wire logic                   strobe_en_in,
    input  wire logic                   strobe_level_in,
    input  wire logic [DIV_W-1:0]       clk_div_in,
    input  wire logic                   supply_reference_switch_set_in,
    input  wire logic                   supply_reference_switch_clr_in,
    // Code writes from CPU or DMA
    input  wire logic                   cur_wr_in,
    input  wire logic [CODE_W-1:0]      cur_data_in,
    input  wire logic                   nxt_wr_in,
    input  wire logic [CODE_W-1:0]      nxt_data_in,
    // Interrupt control
    input  wire logic                   intr_clear_in,
    input  wire logic                   buffer_empty_mask_in,
    // External strobe pin
    input  wire logic                   strobe_in,
    // Converter drive
    output logic [DAC_BIN_W-1:0]        ladder_bits_out,
    output logic [DAC_THERM_W-1:0]      therm_bits_out,
    output logic                        supply_reference_switch_out,
    // Status and events
    output logic [CODE_W-1:0]           current_code_out,
    output logic                        buffer_full_out,
    output logic                        interrupt_status_out,
    output logic                        analog_interrupt_cause_out,
    output logic                        irq_out,
    output logic                        dma_trigger_out
);

    ////////////////////////////////////////////////////////////////////////
    // Thermometer decode of the upper code nibble
    function automatic logic [DAC_THERM_W-1:0] therm_decode(input logic [3:0] nib);
        logic [DAC_THERM_W-1:0] t;
        t = '0;
        for (int i = 0; i < DAC_THERM_W; i++) begin
            t[i] = (nib > 4'(i));
        end
        return t;
    endfunction

    // Mode select from control bits
    function automatic dac_mode_e mode_of(input logic en, input logic lvl, input logic [DIV_W-1:0] div);
        dac_mode_e m;
        m = DAC_MODE_CLOCK;
        if (en && lvl) begin
            m = DAC_MODE_LEVEL;
        end else if (en && div == DIV_W'(1)) begin
            m = DAC_MODE_EDGE_IMM;
        end else if (en) begin
            m = DAC_MODE_EDGE_SYNC;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Strobe synchroniser: first stage read only by the second
    logic [DAC_SYNC_STAGES-1:0] strb_sync_q;
    logic                       strb_prev_q, strb_prev_d;
    logic                       strb_s;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strb_sync_q <= '0;
        end else begin
            strb_sync_q <= {strb_sync_q[0], strobe_in};
        end
    end
    assign strb_s = strb_sync_q[DAC_SYNC_STAGES-1];

    ////////////////////////////////////////////////////////////////////////
    // Update clock divider and strobe qualification
    logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
    logic             tick_q, tick_d;
    logic             armed_q, armed_d;
    logic             strb_rise;
    logic             xfer;
    dac_mode_e        mode;

    assign mode      = mode_of(strobe_en_in, strobe_level_in, clk_div_in);
    assign strb_rise = strb_s & ~strb_prev_q;

    always_comb begin
        div_cnt_d = div_cnt_q;
        tick_d    = 1'b0;
        // Divider of zero is treated as one so the tick never stalls
        if (div_cnt_q + DIV_W'(1) >= clk_div_in) begin
            div_cnt_d = '0;
            tick_d    = 1'b1;
        end else begin
            div_cnt_d = div_cnt_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            tick_q    <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe qualification; the registered tick puts each clocked, edge-sync and level copy one cycle after the wrap
    always_comb begin
        strb_prev_d = strb_s;
        armed_d     = armed_q;
        xfer        = 1'b0;
        if (buffered_mode_in && buffer_full_out) begin
            case (mode)
                DAC_MODE_CLOCK: begin
                    xfer = tick_q;
                end
                DAC_MODE_EDGE_SYNC: begin
                    xfer = tick_q && armed_q;
                end
                DAC_MODE_EDGE_IMM: begin
                    xfer = strb_rise;
                end
                DAC_MODE_LEVEL: begin
                    xfer = tick_q && strb_s;
                end
                default: begin
                    xfer = 1'b0;
                end
            endcase
        end
        // Edge seen earlier waits for the next update tick; a new edge re-arms
        if (xfer) begin
            armed_d = 1'b0;
        end
        if (strb_rise && mode == DAC_MODE_EDGE_SYNC) begin
            armed_d = 1'b1;
        end
        if (mode != DAC_MODE_EDGE_SYNC) begin
            armed_d = 1'b0;
        end
    end

    // Edge detector resets low like the idle strobe, so reset never fakes an edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strb_prev_q <= 1'b0;
            armed_q     <= 1'b0;
        end else begin
            strb_prev_q <= strb_prev_d;
            armed_q     <= armed_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Code storage
    logic [CODE_W-1:0] cur_code;
    logic              full;

    dac_code_reg #(
        .W (CODE_W)
    ) u_code (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .nxt_wr_in   (nxt_wr_in),
        .nxt_data_in (nxt_data_in),
        .cur_wr_in   (cur_wr_in),
        .cur_data_in (cur_data_in),
        .xfer_in     (xfer),
        .nxt_out     (),
        .cur_out     (cur_code),
        .full_out    (full)
    );

    ////////////////////////////////////////////////////////////////////////
    // Format conversion and converter drive
    logic [CODE_W-1:0]      lin_code;
    logic [DAC_BIN_W-1:0]   ladder_q, ladder_d;
    logic [DAC_THERM_W-1:0] therm_q, therm_d;
    logic [CODE_W-1:0]      code_q, code_d;

    always_comb begin
        // Two's complement maps to offset binary by flipping the sign bit
        lin_code = cur_code;
        if (code_format_select_in == FMT_TWOS) begin
            lin_code = {~cur_code[CODE_W-1], cur_code[CODE_W-2:0]};
        end
        ladder_d = lin_code[DAC_BIN_W-1:0];
        therm_d  = therm_decode(lin_code[CODE_W-1:DAC_BIN_W]);
        code_d   = cur_code;
    end

    // Ladder, thermometer and code move together on one edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ladder_q <= '0;
            therm_q  <= '0;
            code_q   <= CODE_RST;
        end else begin
            ladder_q <= ladder_d;
            therm_q  <= therm_d;
            code_q   <= code_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer-empty events: status, masked interrupt and DMA trigger
    logic                   intr_q, intr_d;
    logic                   irq_q, irq_d;
    logic                   dma_q, dma_d;

    always_comb begin
        dma_d  = xfer;
        intr_d = intr_q;
        if (intr_clear_in) begin
            intr_d = 1'b0;
        end
        // A copy in the clear cycle wins, so no empty event is lost
        if (xfer) begin
            intr_d = 1'b1;
        end
        irq_d = intr_d && buffer_empty_mask_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            intr_q <= 1'b0;
            irq_q  <= 1'b0;
            dma_q  <= 1'b0;
        end else begin
            intr_q <= intr_d;
            irq_q  <= irq_d;
            dma_q  <= dma_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supply-reference switch
    logic                   sw_q, sw_d;

    always_comb begin
        sw_d = sw_q;
        // Clearing has priority only when not closed in the same cycle
        if (supply_reference_switch_clr_in) begin
            sw_d = 1'b0;
        end
        if (supply_reference_switch_set_in) begin
            sw_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_q <= 1'b0;
        end else begin
            sw_q <= sw_d;
        end
    end

    assign buffer_full_out             = full;
    assign ladder_bits_out             = ladder_q;
    assign therm_bits_out              = therm_q;
    assign current_code_out            = code_q;
    assign interrupt_status_out        = intr_q;
    assign analog_interrupt_cause_out  = intr_q;
    assign irq_out                     = irq_q;
    assign dma_trigger_out             = dma_q;
    assign supply_reference_switch_out = sw_q;

endmodule

//--- dac_pkg.sv
// Package of constants and types for the DAC update control block
package dac_pkg;
    localparam int          DAC_CODE_W         = 12;
    localparam int          DAC_BIN_W          = 8;
    localparam int          DAC_THERM_W        = 15;
    localparam int          DAC_DIV_W          = 8;
    localparam int          DAC_SYNC_STAGES    = 2;
    // Control field positions
    localparam int          CTRL_FMT_LO        = 24;
    localparam int          CTRL_FMT_HI        = 25;
    localparam int          CTRL_STROBE_EN     = 28;
    localparam int          CTRL_STROBE_LEVEL  = 29;
    localparam int          SW_SUPPLY_REF_BIT  = 0;
    localparam int          INTR_EMPTY_BIT     = 0;
    // Format codes
    localparam logic [1:0]  FMT_UNSIGNED       = 2'h0;
    localparam logic [1:0]  FMT_TWOS           = 2'h1;
    // Reset values
    localparam logic [11:0] CODE_RST           = 12'h000;
    localparam logic [7:0]  DIV_RST            = 8'h01;
    // Update source modes
    typedef enum logic [3:0] {
        DAC_MODE_CLOCK     = 4'b0001,
        DAC_MODE_EDGE_SYNC = 4'b0010,
        DAC_MODE_EDGE_IMM  = 4'b0100,
        DAC_MODE_LEVEL     = 4'b1000
    } dac_mode_e;
endpackage

//--- dac_code_reg.sv
// Double-buffered code storage: next-value buffer and current-value register
`timescale 1ns/1ps
module dac_code_reg
    import dac_pkg::*;
#(
    parameter int W = DAC_CODE_W
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Writes
    input  wire logic         nxt_wr_in,
    input  wire logic [W-1:0] nxt_data_in,
    input  wire logic         cur_wr_in,
    input  wire logic [W-1:0] cur_data_in,
    input  wire logic         xfer_in,
    // Contents
    output logic      [W-1:0] nxt_out,
    output logic      [W-1:0] cur_out,
    output logic              full_out
);
    logic [W-1:0] nxt_q, nxt_d, cur_q, cur_d;
    logic         full_q, full_d;

    always_comb begin
        nxt_d  = nxt_q;
        cur_d  = cur_q;
        full_d = full_q;
        if (xfer_in) begin
            cur_d  = nxt_q;
            full_d = 1'b0;
        end
        // Direct write wins over a buffered copy in the same cycle
        if (cur_wr_in) begin
            cur_d = cur_data_in;
        end
        // A refill in the copy cycle is kept, not lost
        if (nxt_wr_in) begin
            nxt_d  = nxt_data_in;
            full_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nxt_q  <= CODE_RST;
            cur_q  <= CODE_RST;
            full_q <= 1'b0;
        end else begin
            nxt_q  <= nxt_d;
            cur_q  <= cur_d;
            full_q <= full_d;
        end
    end

    assign nxt_out  = nxt_q;
    assign cur_out  = cur_q;
    assign full_out = full_q;
endmodule

//--- dac_update_control_monitor.sv
// Port-level checker of the DAC update control block
`timescale 1ns/1ps
module dac_update_control_monitor
    import dac_pkg::*;
#(
    parameter int CODE_W = DAC_CODE_W,
    parameter int DIV_W  = DAC_DIV_W
) (
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire logic [1:0]             code_format_select_in,
    input wire logic                   buffered_mode_in,
    input wire logic                   strobe_en_in,
    input wire logic                   strobe_level_in,
    input wire logic [DIV_W-1:0]       clk_div_in,
    input wire logic                   supply_reference_switch_set_in,
    input wire logic                   supply_reference_switch_clr_in,
    input wire logic                   cur_wr_in,
    input wire logic [CODE_W-1:0]      cur_data_in,
    input wire logic                   nxt_wr_in,
    input wire logic [CODE_W-1:0]      nxt_data_in,
    input wire logic                   intr_clear_in,
    input wire logic                   buffer_empty_mask_in,
    input wire logic                   strobe_in,
    input wire logic [DAC_BIN_W-1:0]   ladder_bits_out,
    input wire logic [DAC_THERM_W-1:0] therm_bits_out,
    input wire logic                   supply_reference_switch_out,
    input wire logic [CODE_W-1:0]      current_code_out,
    input wire logic                   buffer_full_out,
    input wire logic                   interrupt_status_out,
    input wire logic                   analog_interrupt_cause_out,
    input wire logic                   irq_out,
    input wire logic                   dma_trigger_out
);
    logic [3:0]  top_ob;
    logic [15:0] therm_full;
    // Two's complement only flips the sign bit into offset binary
    assign top_ob = current_code_out[11:8] ^ {code_format_select_in == FMT_TWOS, 3'h0};
    assign therm_full = (16'h1 << top_ob) - 16'h1;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////
    switch_close_a: assert property (supply_reference_switch_set_in |=> supply_reference_switch_out)
        else $error("switch did not close");
    switch_hold_a: assert property (!supply_reference_switch_set_in && !supply_reference_switch_clr_in
        |=> $stable(supply_reference_switch_out)) else $error("switch moved without request");
    // Format only checked when steady, since a change lands one cycle late
    therm_decode_a: assert property ($stable(code_format_select_in)
        |-> therm_bits_out == therm_full[14:0]) else $error("thermometer decode wrong");
    ladder_bits_a: assert property (ladder_bits_out == current_code_out[7:0])
        else $error("ladder bits wrong");
    direct_write_a: assert property (cur_wr_in |-> ##2 current_code_out == $past(cur_data_in, 2))
        else $error("direct write not seen");
    dma_needs_full_a: assert property (dma_trigger_out |-> $past(buffer_full_out))
        else $error("trigger without full buffer");
    dma_sets_status_a: assert property (dma_trigger_out |-> interrupt_status_out)
        else $error("copy did not set status");
    irq_mask_a: assert property (irq_out == (interrupt_status_out && $past(buffer_empty_mask_in)))
        else $error("interrupt not status and mask");
    status_sticky_a: assert property (interrupt_status_out && !intr_clear_in |=> interrupt_status_out)
        else $error("status dropped without clear");
    cause_mirror_a: assert property (analog_interrupt_cause_out == interrupt_status_out)
        else $error("cause differs from status");
    cover property (dma_trigger_out);
    cover property (irq_out);
    cover property ($fell(interrupt_status_out));
endmodule
bind dac_update_control dac_update_control_monitor #(.CODE_W(CODE_W), .DIV_W(DIV_W)) u_mon (.*);

//--- dac_strobe_src.sv
// Model of a peripheral that drives the update strobe
`timescale 1ns/1ps
module dac_strobe_src #(
    parameter int LOW_MIN = 2
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       fire_in,
    input  wire logic [3:0] high_len_in,
    output logic            strobe_out
);
    logic [4:0] cnt_q;
    // High for at least two cycles, then low for at least LOW_MIN plus one cycles before the next pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 5'h00;
            strobe_out <= 1'b0;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
            strobe_out <= (cnt_q - 5'h01) > 5'(LOW_MIN);
        end else if (fire_in) begin
            cnt_q <= 5'((high_len_in < 4'h2) ? 4'h2 : high_len_in) + 5'(LOW_MIN);
            strobe_out <= 1'b1;
        end
    end
endmodule

//--- dac_update_control_tb_top.sv
// Self-checking testbench of the DAC update control block
`timescale 1ns/1ps
module dac_update_control_tb_top;
    import dac_pkg::*;
    typedef struct packed {logic [1:0] f; logic [11:0] c; logic [7:0] l; logic [14:0] t;} dac_row_s;
    logic        clk_in, rst_n_in, buf_m, s_en, s_lvl, sw_set, sw_clr, cur_wr, nxt_wr, clr, mask, fire, strobe;
    logic        sw_out, full, stat, cause, irq, dma;
    logic [1:0]  fmt;
    logic [7:0]  div, ladder;
    logic [11:0] cur_d, nxt_d, code;
    logic [3:0]  hlen;
    logic [14:0] therm;
    int          bad_count = 0;
    int          comparisons = 0;
    int          seen;
    dac_row_s    rows [7] = '{'{2'h0, 12'h000, 8'h00, 15'h0000}, '{2'h0, 12'hfff, 8'hff, 15'h7fff},
        '{2'h0, 12'h5a3, 8'ha3, 15'h001f}, '{2'h1, 12'h800, 8'h00, 15'h0000}, '{2'h1, 12'h000, 8'h00, 15'h00ff},
        '{2'h1, 12'h7ff, 8'hff, 15'h7fff}, '{2'h1, 12'hfff, 8'hff, 15'h007f}};
    ////////////////////////////////////////////////////////////////
    dac_update_control dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .code_format_select_in(fmt),
        .buffered_mode_in(buf_m), .strobe_en_in(s_en), .strobe_level_in(s_lvl), .clk_div_in(div),
        .supply_reference_switch_set_in(sw_set), .supply_reference_switch_clr_in(sw_clr),
        .cur_wr_in(cur_wr), .cur_data_in(cur_d), .nxt_wr_in(nxt_wr), .nxt_data_in(nxt_d),
        .intr_clear_in(clr), .buffer_empty_mask_in(mask), .strobe_in(strobe), .ladder_bits_out(ladder),
        .therm_bits_out(therm), .supply_reference_switch_out(sw_out), .current_code_out(code),
        .buffer_full_out(full), .interrupt_status_out(stat), .analog_interrupt_cause_out(cause),
        .irq_out(irq), .dma_trigger_out(dma));
    dac_strobe_src u_src (.clk_in(clk_in), .rst_n_in(rst_n_in), .fire_in(fire), .high_len_in(hlen),
        .strobe_out(strobe));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    // Strobe select: 0 current write, 1 next write, 2 clear, 3 fire, 4 switch set, other switch clear
    task automatic drive(input int k, input logic v);
        case (k)
            0: cur_wr <= v;
            1: nxt_wr <= v;
            2: clr <= v;
            3: fire <= v;
            4: sw_set <= v;
            default: sw_clr <= v;
        endcase
    endtask
    task automatic pulse(input int k);
        @(posedge clk_in);
        drive(k, 1'b1);
        @(posedge clk_in);
        drive(k, 1'b0);
    endtask
    task automatic wr_nxt(input logic [11:0] v);
        nxt_d <= v;
        pulse(1);
    endtask
    // Counts copies seen over n cycles, sampled mid-cycle once edges settle
    task automatic watch(input int n);
        seen = 0;
        repeat (n) begin
            @(negedge clk_in);
            if (dma === 1'b1) seen++;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {rst_n_in, buf_m, s_en, s_lvl, sw_set, sw_clr, cur_wr, nxt_wr, clr, fire} = '0;
        {fmt, cur_d, nxt_d} = '0;
        mask = 1'b1;
        div = 8'h04;
        hlen = 4'h3;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        chk(code === 12'h000 && stat === 1'b0 && dma === 1'b0 && sw_out === 1'b0, "reset state");
        foreach (rows[i]) begin
            @(posedge clk_in);
            fmt <= rows[i].f;
            cur_d <= rows[i].c;
            pulse(0);
            repeat (3) @(negedge clk_in);
            chk(code === rows[i].c && ladder === rows[i].l && therm === rows[i].t, "direct write");
        end
        @(posedge clk_in);
        fmt <= FMT_UNSIGNED;
        buf_m <= 1'b1;
        wr_nxt(12'h123);
        watch(20);
        chk(seen == 1 && code === 12'h123 && full === 1'b0, "clocked copy");
        chk(stat === 1'b1 && cause === 1'b1 && irq === 1'b1, "status after copy");
        watch(20);
        chk(seen == 0, "copy from empty buffer");
        pulse(2);
        watch(2);
        chk(stat === 1'b0 && irq === 1'b0, "status clear");
        @(posedge clk_in);
        mask <= 1'b0;
        wr_nxt(12'h456);
        watch(20);
        chk(stat === 1'b1 && irq === 1'b0, "masked interrupt");
        @(posedge clk_in);
        s_en <= 1'b1;
        wr_nxt(12'h234);
        watch(24);
        chk(seen == 0 && code === 12'h456 && full === 1'b1, "edge sync waits");
        pulse(3);
        watch(24);
        chk(seen == 1 && code === 12'h234, "edge sync copy");
        @(posedge clk_in);
        div <= 8'h01;
        wr_nxt(12'h345);
        watch(12);
        chk(seen == 0 && full === 1'b1, "edge immediate waits");
        pulse(3);
        watch(12);
        chk(seen == 1 && code === 12'h345, "edge immediate copy");
        @(posedge clk_in);
        s_lvl <= 1'b1;
        div <= 8'h02;
        hlen <= 4'h6;
        wr_nxt(12'habc);
        watch(16);
        chk(seen == 0, "level low blocks");
        pulse(3);
        watch(16);
        chk(seen == 1 && code === 12'habc, "level copy");
        pulse(4);
        watch(1);
        chk(sw_out === 1'b1, "switch close");
        pulse(5);
        watch(1);
        chk(sw_out === 1'b0, "switch open");
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(negedge clk_in);
        chk(code === 12'h000 && stat === 1'b0 && full === 1'b0 && ladder === 8'h00, "mid-run reset");
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        watch(2);
        chk(seen == 0 && stat === 1'b0 && irq === 1'b0, "after mid-run reset");
        tally_and_finish();
    end
endmodule
